// *** design/supervisor_pkg.sv ***
// Purpose: Shared constants for the dual supply reset and watchdog block
// Assumes: 100 MHz system clock
// Notes:   Times are held in their own unit and turned into cycle counts
package supervisor_pkg;

  // ==========================================================================
  // Clock
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 100_000_000;

  // ==========================================================================
  // Timing figures
  // ==========================================================================
  localparam int unsigned RESET_HOLD_MS   = 140;
  localparam int unsigned WD_INITIAL_MS   = 35_000;
  localparam int unsigned WD_NORMAL_MS    = 1_120;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1_000;

  localparam longint unsigned RESET_HOLD_CYC =
    64'(RESET_HOLD_MS) * 64'(CYC_PER_MS);
  localparam longint unsigned WD_INITIAL_CYC =
    64'(WD_INITIAL_MS) * 64'(CYC_PER_MS);
  localparam longint unsigned WD_NORMAL_CYC  =
    64'(WD_NORMAL_MS) * 64'(CYC_PER_MS);

  // ==========================================================================
  // Counter widths
  // ==========================================================================
  localparam int unsigned CNT_W           = 32;

  // Manual reset synchroniser reset value: that input idles high after reset
  localparam logic [1:0]  SYNC_RST        = 2'h3;

endpackage

// *** design/dual_supply_reset_watchdog.sv ***
// Purpose: Reset supervisor combining supply, manual and watchdog causes
// Assumes: Undervoltage flags come from analog comparators, active high
// Notes:   All timing comes from the single 100 MHz clock
`timescale 1ns/10ps

// How it works
// - Secondary reset low while either supply flag or manual reset is active.
// - Secondary reset held one hold period after supplies and manual recover.
// - Manual reset low holds reset, then one more hold period after release.
// - Unconnected manual reset input reads high, so it never resets.
// - Watchdog input static past timeout fires reset for one hold period.
// - Watchdog counter cleared on any reset and on each kick edge.
// - After each reset the watchdog uses the long initial timeout.
// - First kick edge switches the watchdog to the short normal timeout.
// - Primary reset asserts on auxiliary undervoltage, stretched by hold time.
// - A new fault before the hold period ends restarts the hold counter.
// - Primary reset also asserts when the watchdog expires.
// - Power-fail flag follows its comparator, released with no stretch.
module dual_supply_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter longint unsigned HOLD_CYC    = supervisor_pkg::RESET_HOLD_CYC,
  parameter longint unsigned WD_INIT_CYC = supervisor_pkg::WD_INITIAL_CYC,
  parameter longint unsigned WD_NORM_CYC = supervisor_pkg::WD_NORMAL_CYC
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Monitor flags from comparators, high when below threshold
  input  wire logic i_primary_supply_low,
  input  wire logic i_secondary_supply_low,
  input  wire logic i_aux_undervoltage_in,
  input  wire logic i_powerfail_sense,
  // Manual reset and watchdog pins
  input  wire logic i_manual_reset_n,
  input  wire logic i_watchdog_kick,
  // Outputs to the processor
  output logic      o_primary_reset_n,
  output logic      o_secondary_reset_n,
  output logic      o_powerfail_flag_n,
  output logic      o_watchdog_normal
);
  import supervisor_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0]       mr_sync;
    logic [1:0]       wd_sync;
    logic [1:0]       sup_sync;
    logic [1:0]       aux_sync;
    logic [1:0]       pf_sync;
    logic             wd_last;
    logic             wd_normal;
    logic [CNT_W-1:0] wd_cnt;
    logic [CNT_W-1:0] hold1;
    logic [CNT_W-1:0] hold2;
    logic             primary_reset_n_n;
    logic             secondary_reset_n_n;
    logic             pf_n;
  } state_t;

  localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(HOLD_CYC);
  localparam logic [CNT_W-1:0] WDI_C  = CNT_W'(WD_INIT_CYC);
  localparam logic [CNT_W-1:0] WDN_C  = CNT_W'(WD_NORM_CYC);

  state_t st;
  state_t next_st;

  logic sec_fault;
  logic pri_fault;
  logic wd_edge;
  logic wd_expire;
  logic [CNT_W-1:0] wd_limit;

  // ==========================================================================
  // Combinational next state
  // ==========================================================================
  always_comb begin
    next_st = st;
    // Pins pass two flops; a floating manual reset is pulled high upstream
    next_st.mr_sync  = {st.mr_sync[0], i_manual_reset_n};
    next_st.wd_sync  = {st.wd_sync[0], i_watchdog_kick};
    next_st.sup_sync = {st.sup_sync[0],
                        i_primary_supply_low | i_secondary_supply_low};
    next_st.aux_sync = {st.aux_sync[0], i_aux_undervoltage_in};
    next_st.pf_sync  = {st.pf_sync[0], i_powerfail_sense};
    next_st.wd_last  = st.wd_sync[1];

    sec_fault = st.sup_sync[1] | ~st.mr_sync[1];
    wd_edge   = st.wd_sync[1] ^ st.wd_last;
    wd_limit  = st.wd_normal ? WDN_C : WDI_C;
    wd_expire = st.primary_reset_n_n && (st.wd_cnt >= wd_limit - 1'b1);
    pri_fault = sec_fault | st.aux_sync[1] | wd_expire;

    // Secondary reset: supplies and manual reset only
    if (sec_fault) begin
      next_st.hold2  = '0;
      next_st.secondary_reset_n_n = 1'b0;
    end else if (!st.secondary_reset_n_n) begin
      if (st.hold2 >= HOLD_C - 1'b1) begin
        next_st.secondary_reset_n_n = 1'b1;
      end else begin
        next_st.hold2 = st.hold2 + 1'b1;
      end
    end

    // Primary reset: every cause
    if (pri_fault) begin
      next_st.hold1  = '0;
      next_st.primary_reset_n_n = 1'b0;
    end else if (!st.primary_reset_n_n) begin
      if (st.hold1 >= HOLD_C - 1'b1) begin
        next_st.primary_reset_n_n = 1'b1;
      end else begin
        next_st.hold1 = st.hold1 + 1'b1;
      end
    end

    // Watchdog counter and mode
    if (!st.primary_reset_n_n || pri_fault) begin
      next_st.wd_cnt    = '0;
      next_st.wd_normal = 1'b0;
    end else if (wd_edge) begin
      next_st.wd_cnt    = '0;
      next_st.wd_normal = 1'b1;
    end else begin
      next_st.wd_cnt = st.wd_cnt + 1'b1;
    end

    next_st.pf_n = ~st.pf_sync[1];
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      st          <= '0;
      st.mr_sync  <= SYNC_RST;
      st.pf_sync  <= '0;
      st.pf_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_primary_reset_n   = st.primary_reset_n_n;
  assign o_secondary_reset_n = st.secondary_reset_n_n;
  assign o_powerfail_flag_n  = st.pf_n;
  assign o_watchdog_normal   = st.wd_normal;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_sec_clear;
    !sec_fault && !st.secondary_reset_n_n;
  endsequence

  property p_sec_fault_low;
    @(posedge i_clk) disable iff (!i_nrst)
      sec_fault |=> !o_secondary_reset_n;
  endproperty
  a_sec_fault_low: assert property (p_sec_fault_low)
    else $error("secondary reset not driven low on fault");

  property p_sec_hold;
    @(posedge i_clk) disable iff (!i_nrst)
      $rose(o_secondary_reset_n) |-> st.hold2 == HOLD_C - 1'b1;
  endproperty
  a_sec_hold: assert property (p_sec_hold)
    else $error("secondary reset released before hold period");

  property p_mr_primary;
    @(posedge i_clk) disable iff (!i_nrst)
      !st.mr_sync[1] |=> !o_primary_reset_n;
  endproperty
  a_mr_primary: assert property (p_mr_primary)
    else $error("manual reset did not hold primary reset");

  property p_wd_fire;
    @(posedge i_clk) disable iff (!i_nrst)
      wd_expire |=> !o_primary_reset_n && st.wd_cnt == '0;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("watchdog expiry did not assert reset");

  property p_wd_clear_edge;
    @(posedge i_clk) disable iff (!i_nrst)
      wd_edge |=> st.wd_cnt == '0;
  endproperty
  a_wd_clear_edge: assert property (p_wd_clear_edge)
    else $error("watchdog counter not cleared on kick edge");

  property p_init_mode;
    @(posedge i_clk) disable iff (!i_nrst)
      !o_primary_reset_n |=> !o_watchdog_normal;
  endproperty
  a_init_mode: assert property (p_init_mode)
    else $error("watchdog not in initial mode after reset");

  property p_normal_mode;
    @(posedge i_clk) disable iff (!i_nrst)
      o_primary_reset_n && !pri_fault && wd_edge |=> o_watchdog_normal;
  endproperty
  a_normal_mode: assert property (p_normal_mode)
    else $error("watchdog did not enter normal mode on kick");

  property p_aux;
    @(posedge i_clk) disable iff (!i_nrst)
      st.aux_sync[1] |=> !o_primary_reset_n ##1 !o_primary_reset_n;
  endproperty
  a_aux: assert property (p_aux)
    else $error("auxiliary undervoltage did not hold primary reset");

  property p_restart;
    @(posedge i_clk) disable iff (!i_nrst)
      pri_fault ##1 s_sec_clear |-> st.hold1 == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("hold counter not restarted by fault");

  property p_pf;
    @(posedge i_clk) disable iff (!i_nrst)
      ##1 o_powerfail_flag_n == !$past(st.pf_sync[1]);
  endproperty
  a_pf: assert property (p_pf)
    else $error("power-fail flag not following comparator");

endmodule // dual_supply_reset_watchdog

// *** sim/cpu_model.sv ***
// Purpose: Processor model that toggles the watchdog input
// Assumes: Kicks only while primary reset is released
// Notes:   Kick period in clock cycles is a parameter
`timescale 1ns/10ps
module cpu_model #(
  parameter int PERIOD = 20
) (
  // Clock and controls
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_kick_en,
  // Watchdog line
  output logic      o_kick
);
  int cnt = 0;
  initial o_kick = 1'b0;
  // ==========================================================================
  // Kick generator, silent while held in reset
  // ==========================================================================
  always @(posedge i_clk) begin
    if (!i_reset_n || !i_kick_en) begin
      cnt <= 0;
    end else if (cnt == PERIOD - 1) begin
      cnt    <= 0;
      o_kick <= ~o_kick;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // cpu_model

// *** sim/test_dual_supply_reset_watchdog.sv ***
// Purpose: Self-checking bench for the reset supervisor
// Assumes: Shortened hold and watchdog counts
// Notes:   Each scenario is a task of its own
`timescale 1ns/10ps
module test_dual_supply_reset_watchdog;
  import supervisor_pkg::*;
  localparam longint unsigned HOLD = 20;
  localparam longint unsigned WDI0 = 200;
  localparam longint unsigned WDN  = 50;
  logic i_clk = 1'b0, i_nrst = 1'b0, kick_en = 1'b0, kick;
  logic p_low = 1'b0, s_low = 1'b0, aux = 1'b0, pfs = 1'b0, mr_n = 1'b1;
  logic prim_n, sec_n, pf_n, wd_norm;
  int   n_fail = 0, total_checks = 0, n;
  always #5 i_clk = ~i_clk;
  dual_supply_reset_watchdog #(.HOLD_CYC(HOLD), .WD_INIT_CYC(WDI0),
    .WD_NORM_CYC(WDN)) dut (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_primary_supply_low(p_low), .i_secondary_supply_low(s_low),
    .i_aux_undervoltage_in(aux), .i_powerfail_sense(pfs),
    .i_manual_reset_n(mr_n), .i_watchdog_kick(kick),
    .o_primary_reset_n(prim_n), .o_secondary_reset_n(sec_n),
    .o_powerfail_flag_n(pf_n), .o_watchdog_normal(wd_norm));
  cpu_model #(.PERIOD(20)) cpu (.i_clk(i_clk), .i_reset_n(prim_n),
    .i_kick_en(kick_en), .o_kick(kick));
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %b want %b", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return prim_n;
      1: return sec_n;
      2: return pf_n;
      default: return wd_norm;
    endcase
  endfunction
  task automatic wait_for(input int s, input logic lvl, output int c);
    c = 0;
    while (pick(s) !== lvl && c < 2000) begin
      @(posedge i_clk);
      #1;
      c++;
    end
    if (c == 2000) begin
      n_fail++;
      complete_run();
    end
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_power_up();
    repeat (2) @(posedge i_clk);
    #1;
    check(prim_n | sec_n | wd_norm | ~pf_n, 1'b0);
    @(posedge i_clk) i_nrst <= 1'b1;
    wait_for(1, 1'b1, n);
    check(n >= HOLD && n <= HOLD + 5, 1'b1);
    wait_for(0, 1'b0, n);
    check(n >= WDI0 - 5 && n <= WDI0 + 5, 1'b1);
    check(sec_n, 1'b1);
    wait_for(0, 1'b1, n);
    check(n >= HOLD - 1 && n <= HOLD + 2, 1'b1);
    check(wd_norm, 1'b0);
  endtask
  task automatic t_kick();
    @(posedge i_clk) kick_en <= 1'b1;
    wait_for(3, 1'b1, n);
    check(n <= 45, 1'b1);
    repeat (6) begin
      repeat (50) @(posedge i_clk);
      #1;
      check(prim_n, 1'b1);
    end
    @(posedge i_clk) kick_en <= 1'b0;
    wait_for(0, 1'b0, n);
    check(n >= WDN - 22 && n <= WDN + 5, 1'b1);
    check(wd_norm, 1'b0);
    @(posedge i_clk) kick_en <= 1'b1;
    wait_for(0, 1'b1, n);
  endtask
  task automatic t_manual();
    @(posedge i_clk) mr_n <= 1'b0;
    wait_for(1, 1'b0, n);
    check(n <= 4, 1'b1);
    check(prim_n, 1'b0);
    repeat (30) @(posedge i_clk);
    mr_n <= 1'b1;
    wait_for(1, 1'b1, n);
    check(n >= HOLD && n <= HOLD + 4, 1'b1);
  endtask
  task automatic t_glitch();
    @(posedge i_clk) p_low <= 1'b1;
    repeat (5) @(posedge i_clk);
    p_low <= 1'b0;
    repeat (10) @(posedge i_clk);
    s_low <= 1'b1;
    repeat (5) @(posedge i_clk);
    s_low <= 1'b0;
    #1;
    wait_for(1, 1'b1, n);
    check(n >= HOLD && n <= HOLD + 4, 1'b1);
  endtask
  task automatic t_aux_pf();
    @(posedge i_clk) aux <= 1'b1;
    wait_for(0, 1'b0, n);
    check(n <= 4, 1'b1);
    check(sec_n, 1'b1);
    @(posedge i_clk) aux <= 1'b0;
    wait_for(0, 1'b1, n);
    check(n >= HOLD && n <= HOLD + 4, 1'b1);
    @(posedge i_clk) pfs <= 1'b1;
    wait_for(2, 1'b0, n);
    check(n <= 4 && prim_n === 1'b1, 1'b1);
    @(posedge i_clk) pfs <= 1'b0;
    wait_for(2, 1'b1, n);
    check(n <= 4, 1'b1);
  endtask
  initial begin
    t_power_up();
    t_kick();
    t_manual();
    t_glitch();
    t_aux_pf();
    complete_run();
  end
endmodule // test_dual_supply_reset_watchdog
